// File: hw/twx_regs.vh
// register offsets, field positions, reset values and timing of the two-wire block
// assumes a 32-bit Avalon-MM slave port with byte addresses, one aligned word per register
`ifndef TWX_REGS_VH
`define TWX_REGS_VH
`define TWX_OFS_CTRL0 6'h00
`define TWX_OFS_DATA0 6'h04
`define TWX_OFS_PIN0  6'h08
`define TWX_OFS_CTRL1 6'h10
`define TWX_OFS_DATA1 6'h14
`define TWX_OFS_PIN1  6'h18
`define TWX_OFS_FSW   6'h20
`define TWX_OFS_STAT  6'h24
`define TWX_C_EN   0
`define TWX_C_TX   1
`define TWX_C_IEN  2
`define TWX_C_FLAG 3
`define TWX_C_STA  4
`define TWX_C_STP  5
`define TWX_C_BUSY 6
`define TWX_C_DTC  7
`define TWX_C_NACK 8
`define TWX_C_ACKR 9
`define TWX_P_SCL 0
`define TWX_P_SDA 1
`define TWX_P_TXE 2
`define TWX_P_RXF 3
`define TWX_F_EN   0
`define TWX_F_FLAG 1
`define TWX_F_AUTO 2
`define TWX_F_FMT  3
`define TWX_S_TOP  0
`define TWX_S_RAW  2
`define TWX_TOP_NONE 2'h0
`define TWX_TOP_CH0  2'h1
`define TWX_TOP_FSW  2'h2
`define TWX_TOP_CH1  2'h3
`define TWX_TXE_RST 1'b1
`define TWX_FMT_RST 1'b1
`define TWX_CLK_NS 10
`define TWX_QTR_NS 2500
`define TWX_QTR_CNT ((`TWX_QTR_NS + `TWX_CLK_NS - 1) / `TWX_CLK_NS)
`endif

// File: hw/twx_chan.v
// one bus channel: start, byte with acknowledge, and stop on open-drain clock and data
// assumes synchronised pin levels and a quarter-bit enable pulse from the parent
module twx_chan (
  input  wire       clk_in,
  input  wire       sys_rst_in,
  input  wire       tick_in,
  input  wire       go_in,
  input  wire       sta_in,
  input  wire       stp_in,
  input  wire       tx_in,
  input  wire       nack_in,
  input  wire [7:0] byte_in,
  input  wire       scl_in,
  input  wire       sda_in,
  output reg        scl_oe_out,
  output reg        sda_oe_out,
  output wire [7:0] byte_out,
  output reg        ack_out,
  output reg        done_out,
  output wire       wait_out,
  output wire       busy_out
);
  localparam ST_IDLE = 5'b00001;
  localparam ST_STA  = 5'b00010;
  localparam ST_WAIT = 5'b00100;
  localparam ST_BIT  = 5'b01000;
  localparam ST_STO  = 5'b10000;

  reg [4:0] state;
  reg [1:0] ph;
  reg [3:0] bitn;
  reg [7:0] sh;
  reg       tx_m;
  reg       sta_p;
  reg       stp_p;

  assign byte_out = sh;
  assign wait_out = (state == ST_WAIT);
  // busy stays set through the stop phase and drops only after the clock is seen high
  assign busy_out = (state != ST_IDLE);

  always @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      state      <= ST_IDLE;
      ph         <= 2'h0;
      bitn       <= 4'h0;
      sh         <= 8'h00;
      tx_m       <= 1'b0;
      sta_p      <= 1'b0;
      stp_p      <= 1'b0;
      scl_oe_out <= 1'b0;
      sda_oe_out <= 1'b0;
      ack_out    <= 1'b0;
      done_out   <= 1'b0;
    end else begin
      done_out <= 1'b0;
      if (stp_in && (sta_p || state == ST_STA)) begin
        // stop before the start reached the bus: both are lost
        sta_p      <= 1'b0;
        stp_p      <= 1'b0;
        state      <= ST_IDLE;
        ph         <= 2'h0;
        scl_oe_out <= 1'b0;
        sda_oe_out <= 1'b0;
      end else begin
        if (sta_in)
          sta_p <= 1'b1;
        if (stp_in)
          stp_p <= 1'b1;
        if (go_in && state == ST_WAIT) begin
          state <= ST_BIT;
          ph    <= 2'h0;
          bitn  <= 4'h0;
          tx_m  <= tx_in;
          sh    <= tx_in ? byte_in : 8'hFF;
        end else if (tick_in) begin
          case (state)
            ST_IDLE: begin
              if (sta_p && scl_in && sda_in) begin
                state <= ST_STA;
                ph    <= 2'h0;
              end
            end
            ST_STA: begin
              ph <= ph + 2'h1;
              if (ph == 2'h0)
                sda_oe_out <= 1'b1;
              if (ph == 2'h2)
                scl_oe_out <= 1'b1;
              if (ph == 2'h3) begin
                state <= ST_WAIT;
                sta_p <= 1'b0;
              end
            end
            ST_WAIT: begin
              // clock stays low here until the next byte or a stop
              if (stp_p) begin
                state      <= ST_STO;
                ph         <= 2'h0;
                sda_oe_out <= 1'b1;
              end
            end
            ST_BIT: begin
              case (ph)
                2'h0: begin
                  sda_oe_out <= (bitn == 4'h8) ? (!tx_m && !nack_in) : (tx_m && !sh[7]);
                  ph         <= 2'h1;
                end
                2'h1: begin
                  scl_oe_out <= 1'b0;
                  ph         <= 2'h2;
                end
                2'h2: begin
                  // a slave stretching the clock stalls the bit here
                  if (scl_in) begin
                    if (bitn == 4'h8)
                      ack_out <= !sda_in;
                    else
                      sh <= {sh[6:0], sda_in};
                    ph <= 2'h3;
                  end
                end
                default: begin
                  scl_oe_out <= 1'b1;
                  ph         <= 2'h0;
                  if (bitn == 4'h8) begin
                    state      <= ST_WAIT;
                    done_out   <= 1'b1;
                    sda_oe_out <= 1'b0;
                  end else begin
                    bitn <= bitn + 4'h1;
                  end
                end
              endcase
            end
            ST_STO: begin
              if (ph == 2'h1)
                scl_oe_out <= 1'b0;
              if (ph == 2'h2 && scl_in)
                sda_oe_out <= 1'b0;
              if (ph != 2'h2 || scl_in)
                ph <= ph + 2'h1;
              if (ph == 2'h3) begin
                state <= ST_IDLE;
                stp_p <= 1'b0;
              end
            end
            default: begin
              state <= ST_IDLE;
            end
          endcase
        end
      end
    end
  end
endmodule

// File: hw/twx_top.v
// two-channel two-wire unit: registers, byte triggers, interrupt lines and transfer requests
// assumes an Avalon-MM master on clock_in and open-drain pins resolved outside
//
// Summary of operation
// - each interrupt source is gated by its own enable bit and flag.
// - each interrupt line leaves the block as its own independent signal.
// - fixed priority: channel 0 transfer, then format switch, then channel 1.
// - a transfer interrupt on either channel can request the transfer controller.
// - format switch has own flag and enable and never requests the transfer controller.
// - a stop issued before the start appears on the bus cancels both, leaving the bus idle.
// - pin levels stay readable in the pin level register, enabled or not.
// - busy flag clears only after the stop, once the clock line is seen high.
// - transmit: data write or holding-to-shift move starts the next byte.
// - receive: data read or shift-to-holding move starts the next byte.
// - clock is held low after each frame while a data flag is set.
`include "twx_regs.vh"
module twx_top #(
  parameter [15:0] QTR_DIV = `TWX_QTR_CNT
) (
  input  wire        clock_in,
  input  wire        sys_rst_in,
  input  wire [5:0]  avs_address_in,
  input  wire        avs_read_in,
  input  wire        avs_write_in,
  input  wire [31:0] avs_writedata_in,
  output reg  [31:0] avs_readdata_out,
  output reg         avs_waitrequest_out,
  input  wire        scl0_in,
  output reg         scl0_out,
  output wire        scl0_oe_out,
  input  wire        sda0_in,
  output reg         sda0_out,
  output wire        sda0_oe_out,
  input  wire        scl1_in,
  output reg         scl1_out,
  output wire        scl1_oe_out,
  input  wire        sda1_in,
  output reg         sda1_out,
  output wire        sda1_oe_out,
  output reg         xfer_irq_ch0_out,
  output reg         xfer_irq_ch1_out,
  output reg         format_switch_irq_out,
  output reg  [1:0]  irq_top_out,
  output reg         xfer_dtc_req_ch0_out,
  output reg         xfer_dtc_req_ch1_out
);
  // per-channel control fields, bit i is channel i, byte i in the 16-bit registers
  reg  [1:0]  bus_iface_enable;
  reg  [1:0]  transmit_select;
  reg  [1:0]  xfer_irq_enable;
  reg  [1:0]  xfer_irq_flag;
  reg  [1:0]  dtc_enable;
  reg  [1:0]  nack_sel;
  reg  [1:0]  tx_empty_flag;
  reg  [1:0]  rx_full_flag;
  reg  [1:0]  rx_pend;
  reg  [1:0]  rx_kick;
  reg  [1:0]  sta_pulse;
  reg  [1:0]  stp_pulse;
  reg  [1:0]  go_pulse;
  reg  [15:0] tx_holding_reg;
  reg  [15:0] rx_holding_reg;
  reg  [15:0] shift_load;
  // format switch control
  reg         format_switch_enable;
  reg         format_switch_flag;
  reg         format_auto;
  reg         format_two_wire;
  // pin synchronisers, order {sda1, scl1, sda0, scl0}
  reg  [3:0]  pin_meta;
  reg  [3:0]  pin_sync;
  reg         scl0_prev;
  reg  [15:0] qtr_cnt;
  reg         qtr_tick;
  reg  [31:0] rd_mux;
  reg         rd_ch;
  integer     i;

  wire [1:0]  chan_done;
  wire [1:0]  chan_wait;
  wire [1:0]  chan_busy;
  wire [1:0]  chan_ack;
  wire [15:0] chan_byte;
  wire [1:0]  en_eff;
  wire        bus_take;
  wire        wr_go;
  wire        rd_go;
  wire [1:0]  wr_ctrl;
  wire [1:0]  wr_data;
  wire [1:0]  rd_data;
  wire        wr_fsw;
  wire        scl0_fall;
  wire [1:0]  irq_pend;

  // a request completes at the edge where waitrequest is seen low
  assign bus_take  = (avs_read_in || avs_write_in) && avs_waitrequest_out;
  assign wr_go     = avs_write_in && !avs_waitrequest_out;
  assign rd_go     = avs_read_in && !avs_waitrequest_out;
  assign wr_ctrl   = {wr_go && avs_address_in == `TWX_OFS_CTRL1,
                      wr_go && avs_address_in == `TWX_OFS_CTRL0};
  assign wr_data   = {wr_go && avs_address_in == `TWX_OFS_DATA1,
                      wr_go && avs_address_in == `TWX_OFS_DATA0};
  assign rd_data   = {rd_go && avs_address_in == `TWX_OFS_DATA1,
                      rd_go && avs_address_in == `TWX_OFS_DATA0};
  assign wr_fsw    = wr_go && avs_address_in == `TWX_OFS_FSW;
  // channel 0 only moves bytes while the two-wire format is selected
  assign en_eff    = {bus_iface_enable[1], bus_iface_enable[0] && format_two_wire};
  assign scl0_fall = scl0_prev && !pin_sync[0];
  assign irq_pend  = xfer_irq_flag & xfer_irq_enable;

  twx_chan u_chan0 (
    .clk_in     (clock_in),
    .sys_rst_in (sys_rst_in),
    .tick_in    (qtr_tick),
    .go_in      (go_pulse[0]),
    .sta_in     (sta_pulse[0]),
    .stp_in     (stp_pulse[0]),
    .tx_in      (transmit_select[0]),
    .nack_in    (nack_sel[0]),
    .byte_in    (shift_load[7:0]),
    .scl_in     (pin_sync[0]),
    .sda_in     (pin_sync[1]),
    .scl_oe_out (scl0_oe_out),
    .sda_oe_out (sda0_oe_out),
    .byte_out   (chan_byte[7:0]),
    .ack_out    (chan_ack[0]),
    .done_out   (chan_done[0]),
    .wait_out   (chan_wait[0]),
    .busy_out   (chan_busy[0])
  );

  twx_chan u_chan1 (
    .clk_in     (clock_in),
    .sys_rst_in (sys_rst_in),
    .tick_in    (qtr_tick),
    .go_in      (go_pulse[1]),
    .sta_in     (sta_pulse[1]),
    .stp_in     (stp_pulse[1]),
    .tx_in      (transmit_select[1]),
    .nack_in    (nack_sel[1]),
    .byte_in    (shift_load[15:8]),
    .scl_in     (pin_sync[2]),
    .sda_in     (pin_sync[3]),
    .scl_oe_out (scl1_oe_out),
    .sda_oe_out (sda1_oe_out),
    .byte_out   (chan_byte[15:8]),
    .ack_out    (chan_ack[1]),
    .done_out   (chan_done[1]),
    .wait_out   (chan_wait[1]),
    .busy_out   (chan_busy[1])
  );

  // quarter-bit enable for both channels
  always @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      qtr_cnt  <= 16'h0000;
      qtr_tick <= 1'b0;
    end else if (qtr_cnt == QTR_DIV - 16'h0001) begin
      qtr_cnt  <= 16'h0000;
      qtr_tick <= 1'b1;
    end else begin
      qtr_cnt  <= qtr_cnt + 16'h0001;
      qtr_tick <= 1'b0;
    end
  end

  // open-drain pins only ever pull low
  always @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      pin_meta  <= 4'hF;
      pin_sync  <= 4'hF;
      scl0_prev <= 1'b1;
      scl0_out  <= 1'b0;
      sda0_out  <= 1'b0;
      scl1_out  <= 1'b0;
      sda1_out  <= 1'b0;
    end else begin
      pin_meta  <= {sda1_in, scl1_in, sda0_in, scl0_in};
      pin_sync  <= pin_meta;
      scl0_prev <= pin_sync[0];
    end
  end

  always @* begin
    rd_mux = 32'h00000000;
    // address bit 4 picks the channel of a control register
    rd_ch  = avs_address_in[4];
    case (avs_address_in)
      `TWX_OFS_CTRL0, `TWX_OFS_CTRL1: begin
        rd_mux[`TWX_C_EN]   = bus_iface_enable[rd_ch];
        rd_mux[`TWX_C_TX]   = transmit_select[rd_ch];
        rd_mux[`TWX_C_IEN]  = xfer_irq_enable[rd_ch];
        rd_mux[`TWX_C_FLAG] = xfer_irq_flag[rd_ch];
        rd_mux[`TWX_C_BUSY] = chan_busy[rd_ch];
        rd_mux[`TWX_C_DTC]  = dtc_enable[rd_ch];
        rd_mux[`TWX_C_NACK] = nack_sel[rd_ch];
        rd_mux[`TWX_C_ACKR] = chan_ack[rd_ch];
      end
      `TWX_OFS_DATA0: begin
        rd_mux[7:0] = rx_holding_reg[7:0];
      end
      `TWX_OFS_DATA1: begin
        rd_mux[7:0] = rx_holding_reg[15:8];
      end
      `TWX_OFS_PIN0: begin
        // live pin levels regardless of the enable
        rd_mux[`TWX_P_SCL] = pin_sync[0];
        rd_mux[`TWX_P_SDA] = pin_sync[1];
        rd_mux[`TWX_P_TXE] = tx_empty_flag[0];
        rd_mux[`TWX_P_RXF] = rx_full_flag[0];
      end
      `TWX_OFS_PIN1: begin
        rd_mux[`TWX_P_SCL] = pin_sync[2];
        rd_mux[`TWX_P_SDA] = pin_sync[3];
        rd_mux[`TWX_P_TXE] = tx_empty_flag[1];
        rd_mux[`TWX_P_RXF] = rx_full_flag[1];
      end
      `TWX_OFS_FSW: begin
        rd_mux[`TWX_F_EN]   = format_switch_enable;
        rd_mux[`TWX_F_FLAG] = format_switch_flag;
        rd_mux[`TWX_F_AUTO] = format_auto;
        rd_mux[`TWX_F_FMT]  = format_two_wire;
      end
      `TWX_OFS_STAT: begin
        rd_mux[`TWX_S_TOP+1:`TWX_S_TOP] = irq_top_out;
        rd_mux[`TWX_S_RAW+2:`TWX_S_RAW] = {xfer_irq_ch1_out, format_switch_irq_out, xfer_irq_ch0_out};
      end
      default: begin
        rd_mux = 32'h00000000;
      end
    endcase
  end

  // one wait cycle, then the answer; read data is loaded with the grant
  always @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      avs_waitrequest_out <= 1'b1;
      avs_readdata_out    <= 32'h00000000;
    end else if (bus_take) begin
      avs_waitrequest_out <= 1'b0;
      avs_readdata_out    <= rd_mux;
    end else begin
      avs_waitrequest_out <= 1'b1;
    end
  end

  always @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      bus_iface_enable <= 2'b00;
      transmit_select  <= 2'b00;
      xfer_irq_enable  <= 2'b00;
      xfer_irq_flag    <= 2'b00;
      dtc_enable       <= 2'b00;
      nack_sel         <= 2'b00;
      tx_empty_flag    <= {2{`TWX_TXE_RST}};
      rx_full_flag     <= 2'b00;
      rx_pend          <= 2'b00;
      rx_kick          <= 2'b00;
      sta_pulse        <= 2'b00;
      stp_pulse        <= 2'b00;
      go_pulse         <= 2'b00;
      tx_holding_reg   <= 16'h0000;
      rx_holding_reg   <= 16'h0000;
      shift_load       <= 16'h0000;
    end else begin
      for (i = 0; i < 2; i = i + 1) begin
        sta_pulse[i] <= 1'b0;
        stp_pulse[i] <= 1'b0;
        go_pulse[i]  <= 1'b0;
        if (wr_ctrl[i]) begin
          bus_iface_enable[i] <= avs_writedata_in[`TWX_C_EN];
          transmit_select[i]  <= avs_writedata_in[`TWX_C_TX];
          xfer_irq_enable[i]  <= avs_writedata_in[`TWX_C_IEN];
          dtc_enable[i]       <= avs_writedata_in[`TWX_C_DTC];
          nack_sel[i]         <= avs_writedata_in[`TWX_C_NACK];
          sta_pulse[i]        <= avs_writedata_in[`TWX_C_STA] && avs_writedata_in[`TWX_C_EN];
          stp_pulse[i]        <= avs_writedata_in[`TWX_C_STP] && avs_writedata_in[`TWX_C_EN];
          if (!avs_writedata_in[`TWX_C_FLAG])
            xfer_irq_flag[i] <= 1'b0;
        end
        // a frame ending in the clearing cycle keeps the flag
        if (chan_done[i])
          xfer_irq_flag[i] <= 1'b1;
        if (!en_eff[i]) begin
          tx_empty_flag[i] <= 1'b1;
          rx_full_flag[i]  <= 1'b0;
          rx_pend[i]       <= 1'b0;
          rx_kick[i]       <= 1'b0;
        end else if (transmit_select[i]) begin
          // holding-to-shift move while the channel waits
          if (!tx_empty_flag[i] && chan_wait[i] && !go_pulse[i]) begin
            shift_load[i*8 +: 8] <= tx_holding_reg[i*8 +: 8];
            tx_empty_flag[i]     <= 1'b1;
            go_pulse[i]          <= 1'b1;
          end
          // a data write fills holding and so starts the next byte
          if (wr_data[i]) begin
            tx_holding_reg[i*8 +: 8] <= avs_writedata_in[7:0];
            tx_empty_flag[i]         <= 1'b0;
          end
          // an empty holding register leaves the clock held low
        end else begin
          if (rx_kick[i] && chan_wait[i] && !go_pulse[i]) begin
            go_pulse[i] <= 1'b1;
            rx_kick[i]  <= 1'b0;
          end
          // a data read frees holding and starts the next byte
          if (rd_data[i]) begin
            rx_kick[i] <= 1'b1;
            if (rx_pend[i]) begin
              rx_holding_reg[i*8 +: 8] <= chan_byte[i*8 +: 8];
              rx_pend[i]               <= 1'b0;
            end else begin
              rx_full_flag[i] <= 1'b0;
            end
          end
          // shift-to-holding move starts the next byte, else clock held
          if (chan_done[i]) begin
            if (!rx_full_flag[i]) begin
              rx_holding_reg[i*8 +: 8] <= chan_byte[i*8 +: 8];
              rx_full_flag[i]          <= 1'b1;
              rx_kick[i]               <= 1'b1;
            end else begin
              rx_pend[i] <= 1'b1;
            end
          end
        end
      end
    end
  end

  // format switch: a clock fall while armed selects two-wire format
  always @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      format_switch_enable <= 1'b0;
      format_switch_flag   <= 1'b0;
      format_auto          <= 1'b0;
      format_two_wire      <= `TWX_FMT_RST;
    end else begin
      if (wr_fsw) begin
        format_switch_enable <= avs_writedata_in[`TWX_F_EN];
        format_auto          <= avs_writedata_in[`TWX_F_AUTO];
        format_two_wire      <= avs_writedata_in[`TWX_F_FMT];
        if (!avs_writedata_in[`TWX_F_FLAG])
          format_switch_flag <= 1'b0;
      end
      // own flag, set wins over the clear
      if (format_auto && !format_two_wire && scl0_fall) begin
        format_switch_flag <= 1'b1;
        format_two_wire    <= 1'b1;
      end
    end
  end

  always @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      xfer_irq_ch0_out      <= 1'b0;
      xfer_irq_ch1_out      <= 1'b0;
      format_switch_irq_out <= 1'b0;
      irq_top_out           <= `TWX_TOP_NONE;
      xfer_dtc_req_ch0_out  <= 1'b0;
      xfer_dtc_req_ch1_out  <= 1'b0;
    end else begin
      // separate level lines, each flag and enable
      xfer_irq_ch0_out      <= irq_pend[0];
      xfer_irq_ch1_out      <= irq_pend[1];
      format_switch_irq_out <= format_switch_flag && format_switch_enable;
      // transfer controller requests come from transfer interrupts only
      xfer_dtc_req_ch0_out  <= irq_pend[0] && dtc_enable[0];
      xfer_dtc_req_ch1_out  <= irq_pend[1] && dtc_enable[1];
      // highest pending source
      if (irq_pend[0])
        irq_top_out <= `TWX_TOP_CH0;
      else if (format_switch_flag && format_switch_enable)
        irq_top_out <= `TWX_TOP_FSW;
      else if (irq_pend[1])
        irq_top_out <= `TWX_TOP_CH1;
      else
        irq_top_out <= `TWX_TOP_NONE;
    end
  end
endmodule

// File: test/twx_top_assertions.sv
// port-level checker for the two-wire unit: bus handshake, interrupt lines, priority
// assumes it is bound into twx_top and sees only that module's ports
module twx_top_checker (
  input wire logic       clock_in,
  input wire logic       sys_rst_in,
  input wire logic       avs_read_in,
  input wire logic       avs_write_in,
  input wire logic       avs_waitrequest_out,
  input wire logic       xfer_irq_ch0_out,
  input wire logic       xfer_irq_ch1_out,
  input wire logic       format_switch_irq_out,
  input wire logic [1:0] irq_top_out,
  input wire logic       xfer_dtc_req_ch0_out,
  input wire logic       xfer_dtc_req_ch1_out
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (sys_rst_in);
  wait_one_a: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
    else $error("waitrequest low for more than one cycle");
  bus_answer_a: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out |=> !avs_waitrequest_out)
    else $error("request not answered after one wait cycle");
  dtc_ch0_a: assert property (xfer_dtc_req_ch0_out |-> xfer_irq_ch0_out)
    else $error("channel 0 transfer request without its interrupt");
  dtc_ch1_a: assert property (xfer_dtc_req_ch1_out |-> xfer_irq_ch1_out)
    else $error("channel 1 transfer request without its interrupt");
  top_ch0_a: assert property (xfer_irq_ch0_out |-> irq_top_out == 2'h1)
    else $error("channel 0 not on top");
  top_format_a: assert property (format_switch_irq_out && !xfer_irq_ch0_out |-> irq_top_out == 2'h2)
    else $error("format switch not above channel 1");
  top_ch1_a: assert property (xfer_irq_ch1_out && !xfer_irq_ch0_out && !format_switch_irq_out
    |-> irq_top_out == 2'h3)
    else $error("channel 1 not reported");
  top_none_a: assert property (!(xfer_irq_ch0_out || xfer_irq_ch1_out || format_switch_irq_out)
    |-> irq_top_out == 2'h0)
    else $error("priority code with nothing pending");
  cover property (xfer_irq_ch0_out && xfer_irq_ch1_out);
  cover property (format_switch_irq_out && xfer_irq_ch1_out);
  cover property ($fell(xfer_irq_ch1_out));
endmodule

// File: test/twx_slave_model.sv
// behavioural target on one two-wire channel: acks each byte and records its data bits
// assumes resolved pin levels with pull-ups; slow_in stretches every low clock phase
module twx_slave_model (
  input  wire logic       clk_in,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  input  wire logic       slow_in,
  output logic            scl_pull_out,
  output logic            sda_pull_out,
  output logic [7:0]      byte_out
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt = -2;
  initial begin
    scl_pull_out = 1'b0;
    sda_pull_out = 1'b0;
    byte_out = 8'h00;
  end
  always @(negedge sda_in) if (scl_in) cnt = -1;
  always @(posedge scl_in) if (cnt >= 0 && cnt < 8) byte_out = {byte_out[6:0], sda_in};
  always @(negedge scl_in) begin
    cnt = (cnt == 8) ? 0 : cnt + 1;
    sda_pull_out = (cnt == 8);
  end
  always @(negedge scl_in) if (slow_in) begin
    scl_pull_out = 1'b1;
    repeat (12) @(posedge clk_in);
    scl_pull_out = 1'b0;
  end
endmodule

// File: test/twx_top_tb_top.sv
// self-checking bench for the two-wire unit with a target model on each channel
// assumes open-drain lines resolved here with pull-ups
module twx_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock_in, sys_rst_in, avs_read_in, avs_write_in, tb_scl0_pull;
  logic [5:0]  avs_address_in;
  logic [31:0] avs_writedata_in, rdat;
  wire  [31:0] avs_readdata_out;
  wire  [1:0]  irq_top_out;
  wire  [7:0]  m0_byte, m1_byte;
  wire avs_waitrequest_out, scl0_out, sda0_out, scl1_out, sda1_out, scl0_oe_out, sda0_oe_out;
  wire scl1_oe_out, sda1_oe_out, xfer_irq_ch0_out, xfer_irq_ch1_out, format_switch_irq_out;
  wire xfer_dtc_req_ch0_out, xfer_dtc_req_ch1_out, m0_scl, m0_sda, m1_scl, m1_sda;
  int n_mismatch, check_count, cyc;
  logic [5:0]  ra [6] = '{6'h08, 6'h18, 6'h20, 6'h24, 6'h00, 6'h3C};
  logic [31:0] re [6] = '{32'h7, 32'h7, 32'h8, 32'h0, 32'h0, 32'h0};
  logic [5:0]  wa [3] = '{6'h00, 6'h20, 6'h10};
  logic [31:0] wd [3] = '{32'h87, 32'h9, 32'h8B};
  logic [1:0]  wt [3] = '{2'h2, 2'h3, 2'h0};
  wire scl0_in = !(scl0_oe_out | m0_scl | tb_scl0_pull);
  wire sda0_in = !(sda0_oe_out | m0_sda);
  wire scl1_in = !(scl1_oe_out | m1_scl);
  wire sda1_in = !(sda1_oe_out | m1_sda);
  twx_top #(.QTR_DIV(16'h0004)) u_twx_top (.*);
  twx_slave_model u_twx_slave_model_0 (.clk_in(clock_in), .scl_in(scl0_in), .sda_in(sda0_in), .slow_in(1'b0),
    .scl_pull_out(m0_scl), .sda_pull_out(m0_sda), .byte_out(m0_byte));
  twx_slave_model u_twx_slave_model_1 (.clk_in(clock_in), .scl_in(scl1_in), .sda_in(sda1_in), .slow_in(1'b1),
    .scl_pull_out(m1_scl), .sda_pull_out(m1_sda), .byte_out(m1_byte));
  initial begin
    clock_in = 1'b0;
    forever #5 clock_in = ~clock_in;
  end
  task summarize;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge clock_in) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      n_mismatch++;
      summarize();
    end
  end
  task chk(input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  // one Avalon transfer: held until waitrequest is sampled low
  task bus(input logic w, input logic [5:0] a, input logic [31:0] d);
    @(posedge clock_in);
    avs_address_in <= a;
    avs_write_in <= w;
    avs_read_in <= !w;
    avs_writedata_in <= d;
    do @(posedge clock_in); while (avs_waitrequest_out !== 1'b0);
    rdat = avs_readdata_out;
    avs_write_in <= 1'b0;
    avs_read_in <= 1'b0;
  endtask
  task tx(input logic [5:0] o, input logic [7:0] d);
    int n;
    n = 0;
    bus(1'b1, o, 32'h97);
    do begin
      bus(1'b0, o + 6'h08, 32'h0);
      n++;
    end while (rdat[1:0] !== 2'h0 && n < 300);
    chk(rdat[1:0], 32'h0);
    bus(1'b1, o + 6'h04, {24'h0, d});
    while ((o[4] ? xfer_irq_ch1_out : xfer_irq_ch0_out) !== 1'b1 && n < 3000) begin
      @(posedge clock_in);
      n++;
    end
    @(posedge clock_in);
  endtask
  initial begin
    cyc = 0; n_mismatch = 0; check_count = 0; sys_rst_in = 1'b1; avs_read_in = 1'b0; avs_write_in = 1'b0;
    avs_address_in = 6'h00; avs_writedata_in = 32'h0; tb_scl0_pull = 1'b0;
    repeat (8) @(posedge clock_in);
    chk({avs_waitrequest_out, irq_top_out, xfer_irq_ch0_out, xfer_irq_ch1_out, format_switch_irq_out,
      xfer_dtc_req_ch0_out, xfer_dtc_req_ch1_out, scl0_out, sda0_out, scl1_out, sda1_out}, 32'h800);
    sys_rst_in <= 1'b0;
    for (int i = 0; i < 6; i++) begin
      bus(1'b0, ra[i], 32'h0);
      chk(rdat, re[i]);
    end
    $display("reset values done");
    // stop right behind start: both must be dropped, bus left idle
    bus(1'b1, 6'h10, 32'h11);
    bus(1'b1, 6'h10, 32'h21);
    repeat (40) @(posedge clock_in);
    bus(1'b0, 6'h10, 32'h0);
    chk(rdat, 32'h1);
    bus(1'b0, 6'h18, 32'h0);
    chk(rdat[1:0], 32'h3);
    $display("start stop abort done");
    bus(1'b1, 6'h20, 32'h5);
    tb_scl0_pull <= 1'b1;
    repeat (4) @(posedge clock_in);
    tb_scl0_pull <= 1'b0;
    repeat (6) @(posedge clock_in);
    chk({format_switch_irq_out, irq_top_out, xfer_dtc_req_ch0_out, xfer_dtc_req_ch1_out}, 32'h18);
    $display("format switch done");
    tx(6'h10, 8'h3C);
    chk({xfer_irq_ch1_out, xfer_dtc_req_ch1_out, irq_top_out}, 32'hE);
    chk(m1_byte, 32'h3C);
    tx(6'h00, 8'hA5);
    chk({xfer_irq_ch0_out, xfer_dtc_req_ch0_out, irq_top_out}, 32'hD);
    chk(m0_byte, 32'hA5);
    $display("transmit bytes done");
    for (int i = 0; i < 3; i++) begin
      bus(1'b1, wa[i], wd[i]);
      repeat (3) @(posedge clock_in);
      chk(irq_top_out, wt[i]);
    end
    chk({xfer_irq_ch0_out, xfer_irq_ch1_out, format_switch_irq_out, xfer_dtc_req_ch0_out,
      xfer_dtc_req_ch1_out}, 32'h0);
    $display("interrupt clearing done");
    // receive on channel 1: a data read starts the byte, the holding move starts the next
    bus(1'b1, 6'h10, 32'h5);
    bus(1'b0, 6'h14, 32'h0);
    chk(rdat, 32'h0);
    while (xfer_irq_ch1_out !== 1'b1) @(posedge clock_in);
    bus(1'b0, 6'h18, 32'h0);
    chk(rdat[3], 32'h1);
    bus(1'b0, 6'h14, 32'h0);
    chk(rdat, 32'hFF);
    $display("receive byte done");
    summarize();
  end
endmodule
bind twx_top twx_top_checker u_twx_top_checker (.*);
